// ### src/ars_pkg.sv
// Constants, register map and field layout of the receiver error, status and interrupt block.
package ars_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] ARS_IDX_CTRL    = 6'h02;
	localparam logic [5:0] ARS_IDX_PATH    = 6'h04;
	localparam logic [5:0] ARS_IDX_FMASK   = 6'h0e;
	localparam logic [5:0] ARS_IDX_IMASK   = 6'h0f;
	localparam logic [5:0] ARS_IDX_IMODE   = 6'h10;
	localparam logic [5:0] ARS_IDX_FORMAT  = 6'h12;
	localparam logic [5:0] ARS_IDX_FFLAGS  = 6'h13;
	localparam logic [5:0] ARS_IDX_ISTAT   = 6'h14;
	localparam logic [5:0] ARS_IDX_BURST0  = 6'h2d;
	localparam logic [5:0] ARS_IDX_BURST3  = 6'h30;
	localparam int         ARS_AW          = 8;
	localparam int         ARS_DW          = 32;
	localparam logic [7:0] ARS_RST_BYTE    = 8'h00;
	// Control fields.
	localparam int ARS_CTRL_XTI      = 0;
	localparam int ARS_CTRL_IRQ_LO   = 1;
	localparam int ARS_PATH_HOLD_LO  = 0;
	localparam int ARS_PATH_PINCFG   = 2;
	localparam int ARS_PATH_DEEMPH   = 3;
	localparam int ARS_PATH_WCMASTER = 4;
	localparam int ARS_PATH_FALLEDGE = 5;
	localparam int ARS_PATH_DIRECT   = 6;
	// Fault bit positions, shared by mask and flag registers.
	localparam int ARS_F_WORD   = 0;
	localparam int ARS_F_LINE   = 1;
	localparam int ARS_F_JITTER = 2;
	localparam int ARS_F_VALID  = 3;
	localparam int ARS_F_UNLOCK = 4;
	localparam int ARS_F_STCRC  = 5;
	localparam int ARS_F_SUBCRC = 6;
	localparam int ARS_NFAULT   = 7;
	localparam logic [6:0] ARS_SAMPLE_FAULTS = 7'h1f;
	localparam logic [6:0] ARS_ALL_FAULTS    = 7'h7f;
	localparam logic [6:0] ARS_VALID_BIT     = 7'h08;
	// Interrupt sources and trigger modes.
	localparam int ARS_NIRQ = 4;
	typedef enum logic [1:0] {ARS_TRIG_LEVEL, ARS_TRIG_RISE, ARS_TRIG_FALL, ARS_TRIG_OFF} ars_trig_t;
	typedef enum logic [1:0] {ARS_HOLD_REPEAT, ARS_HOLD_MUTE, ARS_HOLD_PASS, ARS_HOLD_RSVD} ars_hold_t;
	typedef enum logic [1:0] {ARS_INT_LOW, ARS_INT_HIGH, ARS_INT_OD, ARS_INT_RSVD} ars_int_t;
	// Audio path and latency.
	localparam int ARS_SW          = 24;
	localparam int ARS_DEPTH       = 8;
	localparam int ARS_TAP_DIRECT  = 5;
	localparam int ARS_TAP_OTHER   = 7;
	localparam int ARS_CW          = 16;
	localparam int ARS_CLK_MHZ     = 100;
	localparam int ARS_SYNC_TMO_US = 100;
	localparam int ARS_SYNC_TMO_CYC = ARS_SYNC_TMO_US * ARS_CLK_MHZ;
endpackage

// ### src/ars_rx_status.sv
// Receiver error flags, sample hold, format and interrupt reporting with an Avalon-MM register slave.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ars_rx_status #(
	parameter int SYNC_TMO_CYC = ars_pkg::ARS_SYNC_TMO_CYC
) (
	// Clock and reset.
	input  wire logic                      mclk_i,
	input  wire logic                      arst_n_i,
	// Avalon-MM slave.
	input  wire logic [ars_pkg::ARS_AW-1:0] avs_address_i,
	input  wire logic                      avs_read_i,
	input  wire logic                      avs_write_i,
	input  wire logic [ars_pkg::ARS_DW-1:0] avs_writedata_i,
	output logic      [ars_pkg::ARS_DW-1:0] avs_readdata_o,
	output logic                           avs_waitrequest_o,
	// Receiver decoder status, same clock.
	input  wire logic                      subframe_strobe_i,
	input  wire logic                      preamble_xz_i,
	input  wire logic                      preamble_y_i,
	input  wire logic                      word_check_error_i,
	input  wire logic                      line_code_error_i,
	input  wire logic                      jitter_margin_error_i,
	input  wire logic                      validity_error_i,
	input  wire logic                      unlock_error_i,
	input  wire logic                      status_block_checksum_error_i,
	input  wire logic                      subcode_checksum_error_i,
	input  wire logic                      burst_sync_i,
	input  wire logic                      cs_bit1_i,
	input  wire logic [4:0]                format_found_i,
	input  wire logic [31:0]               burst_preamble_i,
	// Audio samples.
	input  wire logic [ars_pkg::ARS_SW-1:0] sample_i,
	input  wire logic                      channel_b_i,
	output logic      [ars_pkg::ARS_SW-1:0] sample_o,
	output logic                           sample_valid_o,
	output logic                           slave_aligned_o,
	// Clock selection and de-emphasis.
	output logic                           clk_switch_xti_o,
	output logic                           deemph_bypass_o,
	output logic                           non_audio_o,
	// Fault outputs.
	output logic                           receive_fault_flag_o,
	output logic                           fault_flag_excluding_validity_o,
	output logic                           receive_fault_pulse_o,
	input  wire logic                      combined_fault_pin_i,
	output logic                           combined_fault_pin_o,
	output logic                           combined_fault_pin_oe_n_o,
	// Word clock pin.
	input  wire logic                      output_word_clock_i,
	output logic                           output_word_clock_o,
	output logic                           output_word_clock_oe_n_o,
	// Interrupt pin.
	output logic                           irq_o,
	output logic                           irq_oe_n_o
);
	import ars_pkg::*;

	logic [1:0] rst_sync_q;
	logic       rst_n;

	// Reset release passes two flops so that all logic leaves reset on one edge.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pin synchronisers; only the second stage is read.
	// They carry no reset, so the strap has passed both stages by the time the internal reset releases.
	logic [1:0] strap_s_q, wclk_s_q;
	always_ff @(posedge mclk_i) begin
		strap_s_q <= {strap_s_q[0], combined_fault_pin_i};
		wclk_s_q  <= {wclk_s_q[0], output_word_clock_i};
	end

	// Register file state.
	logic [7:0] ctrl_q, ctrl_d, path_q, path_d, fmask_q, fmask_d, imask_q, imask_d, imode_q, imode_d;
	logic [6:0] fflags_q, fflags_d;
	logic [3:0] istat_q, istat_d;
	logic       ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic       req, wr_acc, rd_acc;
	logic [5:0] idx;
	logic [6:0] err_now, err_unm, flag_set;
	logic [3:0] irq_set;

	assign req    = avs_read_i | avs_write_i;
	assign idx    = avs_address_i[7:2];
	assign wr_acc = avs_write_i & ack_q;
	assign rd_acc = avs_read_i & ack_q;
	// One wait state: read data is registered and is valid as waitrequest falls.
	assign avs_waitrequest_o = req & ~ack_q;
	assign avs_readdata_o    = rdata_q;

	// Reads a register by index; unmapped addresses read as zero.
	function automatic logic [7:0] reg_rd(input logic [5:0] i);
		logic [7:0] v;
		v = ARS_RST_BYTE;
		unique case (i)
			ARS_IDX_CTRL:   v = ctrl_q;
			ARS_IDX_PATH:   v = path_q;
			ARS_IDX_FMASK:  v = fmask_q;
			ARS_IDX_IMASK:  v = imask_q;
			ARS_IDX_IMODE:  v = imode_q;
			ARS_IDX_FORMAT: v = {3'b000, format_found_i};
			ARS_IDX_FFLAGS: v = {1'b0, fflags_q};
			ARS_IDX_ISTAT:  v = {4'h0, istat_q};
			default: begin
				if (i >= ARS_IDX_BURST0 && i <= ARS_IDX_BURST3) begin
					v = burst_preamble_i[8*(i-ARS_IDX_BURST0) +: 8];
				end
			end
		endcase
		return v;
	endfunction

	// Bus handshake, register writes and read-to-clear of the sticky flags.
	always_comb begin
		ack_d   = req & ~ack_q;
		rdata_d = rdata_q;
		if (req && !ack_q) begin
			rdata_d = {24'h00_0000, reg_rd(idx)};
		end
		ctrl_d  = ctrl_q;
		path_d  = path_q;
		fmask_d = fmask_q;
		imask_d = imask_q;
		imode_d = imode_q;
		if (wr_acc) begin
			unique case (idx)
				ARS_IDX_CTRL:  ctrl_d  = avs_writedata_i[7:0];
				ARS_IDX_PATH:  path_d  = avs_writedata_i[7:0];
				ARS_IDX_FMASK: fmask_d = avs_writedata_i[7:0];
				ARS_IDX_IMASK: imask_d = avs_writedata_i[7:0];
				ARS_IDX_IMODE: imode_d = avs_writedata_i[7:0];
				default:       ctrl_d  = ctrl_q;
			endcase
		end
		// A fault in the clearing cycle survives the read.
		fflags_d = ((rd_acc && idx == ARS_IDX_FFLAGS) ? 7'h00 : fflags_q) | flag_set;
		istat_d  = ((rd_acc && idx == ARS_IDX_ISTAT) ? 4'h0 : istat_q) | irq_set;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			ack_q    <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			ctrl_q   <= ARS_RST_BYTE;
			path_q   <= ARS_RST_BYTE;
			fmask_q  <= ARS_RST_BYTE;
			imask_q  <= ARS_RST_BYTE;
			imode_q  <= ARS_RST_BYTE;
			fflags_q <= 7'h00;
			istat_q  <= 4'h0;
		end else begin
			ack_q    <= ack_d;
			rdata_q  <= rdata_d;
			ctrl_q   <= ctrl_d;
			path_q   <= path_d;
			fmask_q  <= fmask_d;
			imask_q  <= imask_d;
			imode_q  <= imode_d;
			fflags_q <= fflags_d;
			istat_q  <= istat_d;
		end
	end

	// Fault collection and level outputs.
	logic pincfg, strap_done_q, strap_done_d, strap_full_q, strap_full_d;
	logic receive_fault_flag_q, receive_fault_flag_d, fault_flag_excluding_validity_q, fault_flag_excluding_validity_d, pulse_q, pulse_d, full_sel;
	logic [6:0] eff_mask;

	assign pincfg   = path_q[ARS_PATH_PINCFG];
	assign full_sel = strap_full_q;
	assign err_now  = {subcode_checksum_error_i, status_block_checksum_error_i, unlock_error_i,
	                   validity_error_i, jitter_margin_error_i, line_code_error_i, word_check_error_i};
	// Pin configuration enables every fault, validity only when the full fault is chosen.
	assign eff_mask = pincfg ? (full_sel ? ARS_ALL_FAULTS : (ARS_ALL_FAULTS & ~ARS_VALID_BIT))
	                         : fmask_q[6:0];
	assign err_unm  = err_now & eff_mask;
	assign flag_set = subframe_strobe_i ? err_unm : 7'h00;

	always_comb begin
		strap_done_d = 1'b1;
		strap_full_d = strap_done_q ? strap_full_q : strap_s_q[1];
		receive_fault_flag_d  = receive_fault_flag_q;
		fault_flag_excluding_validity_d = fault_flag_excluding_validity_q;
		pulse_d = 1'b0;
		if (subframe_strobe_i) begin
			receive_fault_flag_d  = |err_unm;
			fault_flag_excluding_validity_d = |(err_unm & ~ARS_VALID_BIT);
			pulse_d = |err_unm;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'b0;
			strap_full_q <= 1'b0;
			receive_fault_flag_q       <= 1'b0;
			fault_flag_excluding_validity_q      <= 1'b0;
			pulse_q      <= 1'b0;
		end else begin
			strap_done_q <= strap_done_d;
			strap_full_q <= strap_full_d;
			receive_fault_flag_q       <= receive_fault_flag_d;
			fault_flag_excluding_validity_q      <= fault_flag_excluding_validity_d;
			pulse_q      <= pulse_d;
		end
	end

	assign receive_fault_flag_o            = receive_fault_flag_q;
	assign fault_flag_excluding_validity_o = fault_flag_excluding_validity_q;
	assign receive_fault_pulse_o           = pulse_q;
	// The pin stays released until the strap is caught, then drives the chosen fault.
	assign combined_fault_pin_o      = full_sel ? receive_fault_flag_q : fault_flag_excluding_validity_q;
	assign combined_fault_pin_oe_n_o = ~strap_done_q;
	assign clk_switch_xti_o = unlock_error_i & (ctrl_q[ARS_CTRL_XTI] | pincfg);

	// Compressed sync detection and non-audio indication.
	logic [31:0] tmo_q, tmo_d;
	logic        sync_q, sync_d;
	always_comb begin
		tmo_d  = tmo_q;
		sync_d = sync_q;
		if (burst_sync_i) begin
			sync_d = 1'b1;
			tmo_d  = 32'd0;
		end else if (sync_q) begin
			tmo_d = tmo_q + 32'd1;
			if (tmo_q >= 32'(SYNC_TMO_CYC) - 32'd1) begin
				sync_d = 1'b0;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			tmo_q  <= 32'd0;
			sync_q <= 1'b0;
		end else begin
			tmo_q  <= tmo_d;
			sync_q <= sync_d;
		end
	end
	assign non_audio_o     = sync_q | cs_bit1_i;
	assign deemph_bypass_o = path_q[ARS_PATH_DEEMPH] & non_audio_o;

	// Sample treatment and latency line; only the treated sample differs from normal audio.
	ars_hold_t hold_sel;
	logic [ARS_SW-1:0] dly_q [ARS_DEPTH];
	logic [ARS_SW-1:0] dly_d [ARS_DEPTH];
	logic [ARS_SW-1:0] prev_a_q, prev_a_d, prev_b_q, prev_b_d, treated, out_q, out_d;
	logic vld_q, vld_d, hit;

	assign hold_sel = pincfg ? ARS_HOLD_REPEAT : ars_hold_t'(path_q[ARS_PATH_HOLD_LO +: 2]);
	assign hit      = |(err_unm & ARS_SAMPLE_FAULTS) | (pincfg & |(err_unm & ~ARS_SAMPLE_FAULTS));

	always_comb begin
		treated = sample_i;
		if (hit) begin
			unique case (hold_sel)
				ARS_HOLD_REPEAT: treated = channel_b_i ? prev_b_q : prev_a_q;
				ARS_HOLD_MUTE:   treated = '0;
				default:         treated = sample_i;
			endcase
		end
		prev_a_d = prev_a_q;
		prev_b_d = prev_b_q;
		dly_d    = dly_q;
		out_d    = out_q;
		vld_d    = subframe_strobe_i;
		if (subframe_strobe_i) begin
			if (channel_b_i) begin
				prev_b_d = treated;
			end else begin
				prev_a_d = treated;
			end
			dly_d[0] = treated;
			for (int k = 1; k < ARS_DEPTH; k++) begin
				dly_d[k] = dly_q[k-1];
			end
			// Three frames in direct passthrough, four otherwise.
			out_d = path_q[ARS_PATH_DIRECT] ? dly_q[ARS_TAP_DIRECT] : dly_q[ARS_TAP_OTHER];
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			prev_a_q <= '0;
			prev_b_q <= '0;
			out_q    <= '0;
			vld_q    <= 1'b0;
			for (int k = 0; k < ARS_DEPTH; k++) begin
				dly_q[k] <= '0;
			end
		end else begin
			prev_a_q <= prev_a_d;
			prev_b_q <= prev_b_d;
			out_q    <= out_d;
			vld_q    <= vld_d;
			dly_q    <= dly_d;
		end
	end
	assign sample_o       = out_q;
	assign sample_valid_o = vld_q;

	// Word clock: driven from preambles as master, checked for alignment as slave.
	logic wc_q, wc_d, wprev_q, wprev_d, align_q, align_d, wedge, master;
	logic [ARS_CW-1:0] flen_q, flen_d, fcnt_q, fcnt_d, since_q, since_d, quarter;
	assign master  = path_q[ARS_PATH_WCMASTER];
	assign quarter = flen_q >> 2;
	assign wedge   = path_q[ARS_PATH_FALLEDGE] ? (wprev_q & ~wclk_s_q[1]) : (~wprev_q & wclk_s_q[1]);
	always_comb begin
		wc_d    = wc_q;
		wprev_d = wclk_s_q[1];
		align_d = 1'b0;
		fcnt_d  = (&fcnt_q) ? fcnt_q : fcnt_q + 1'b1;
		since_d = wedge ? '0 : ((&since_q) ? since_q : since_q + 1'b1);
		flen_d  = flen_q;
		if (preamble_xz_i) begin
			wc_d   = ~path_q[ARS_PATH_FALLEDGE];
			fcnt_d = '0;
			flen_d = fcnt_q;
			align_d = ~master & ((since_q <= quarter) | (since_q >= flen_q - quarter));
		end else if (preamble_y_i) begin
			wc_d = path_q[ARS_PATH_FALLEDGE];
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			wc_q    <= 1'b0;
			wprev_q <= 1'b0;
			align_q <= 1'b0;
			fcnt_q  <= '0;
			since_q <= '0;
			flen_q  <= '0;
		end else begin
			wc_q    <= wc_d;
			wprev_q <= wprev_d;
			align_q <= align_d;
			fcnt_q  <= fcnt_d;
			since_q <= since_d;
			flen_q  <= flen_d;
		end
	end
	assign output_word_clock_o      = master & wc_q;
	assign output_word_clock_oe_n_o = ~master;
	assign slave_aligned_o          = align_q;

	// Interrupt sources with per-source trigger mode and pin style.
	logic [3:0] cond, cprev_q, cprev_d;
	logic       irq_act;
	ars_int_t   int_style;
	assign cond = {sync_q, unlock_error_i, non_audio_o, receive_fault_flag_q};
	always_comb begin
		cprev_d = cond;
		irq_set = '0;
		for (int s = 0; s < ARS_NIRQ; s++) begin
			unique case (ars_trig_t'(imode_q[2*s +: 2]))
				ARS_TRIG_LEVEL: irq_set[s] = cond[s];
				ARS_TRIG_RISE:  irq_set[s] = cond[s] & ~cprev_q[s];
				ARS_TRIG_FALL:  irq_set[s] = ~cond[s] & cprev_q[s];
				default:        irq_set[s] = 1'b0;
			endcase
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			cprev_q <= 4'h0;
		end else begin
			cprev_q <= cprev_d;
		end
	end
	assign irq_act   = |(istat_q & imask_q[3:0]);
	assign int_style = ars_int_t'(ctrl_q[ARS_CTRL_IRQ_LO +: 2]);
	// Open drain pulls low only while asserted so several devices can share one line.
	assign irq_o      = (int_style == ARS_INT_HIGH) ? irq_act : (int_style == ARS_INT_OD ? 1'b0 : ~irq_act);
	assign irq_oe_n_o = (int_style == ARS_INT_OD) ? ~irq_act : 1'b0;
endmodule
`default_nettype wire

// ### sim/ars_host_model.sv
// Host controller model that reaches the block's registers over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ars_host_model (
	// Bus clock.
	input  wire logic        clk_i,
	// Slave answer.
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i,
	// Requests.
	output var logic [7:0]   address_o,
	output var logic         read_o,
	output var logic         write_o,
	output var logic [31:0]  writedata_o
);
	// The bus idles at time zero so the slave never sees an unknown request.
	initial begin
		address_o = 8'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h0000_0000;
	end
	// One access; the request stands until waitrequest is sampled low at a rising edge.
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		address_o <= {idx, 2'b00};
		writedata_o <= {24'h00_0000, d};
		write_o <= wr;
		read_o <= !wr;
		@(posedge clk_i);
		while (waitrequest_i !== 1'b0) @(posedge clk_i);
		q = readdata_i[7:0];
		write_o <= 1'b0;
		read_o <= 1'b0;
		// Released lines are scrambled so a slave that still looks at them is caught.
		address_o <= ~address_o;
		writedata_o <= ~writedata_o;
	endtask
endmodule
`default_nettype wire

// ### sim/ars_rx_status_assertions.sv
// Concurrent checks on the ports of the receiver status block.
`timescale 1ns/1ps
`default_nettype none
module ars_rx_status_assertions (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// Register bus.
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// Receiver side.
	input wire logic subframe_strobe_i,
	input wire logic burst_sync_i,
	input wire logic cs_bit1_i,
	input wire logic sample_valid_o,
	input wire logic non_audio_o,
	// Faults and interrupt.
	input wire logic receive_fault_flag_o,
	input wire logic fault_flag_excluding_validity_o,
	input wire logic receive_fault_pulse_o,
	input wire logic irq_o,
	input wire logic irq_oe_n_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	// A request first stalls, then is acknowledged on the next cycle.
	sequence s_stall; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
	sequence s_ack; (avs_read_i || avs_write_i) && !avs_waitrequest_o; endsequence
	property p_ack; s_stall |=> s_ack; endproperty
	a_ack: assert property (p_ack)
		else $error("Register access not acknowledged one cycle after request.");
	// Fault levels move only at subframe boundaries, never on register reads.
	property p_flag_stable; !$past(subframe_strobe_i) |-> $stable(receive_fault_flag_o); endproperty
	a_flag_stable: assert property (p_flag_stable)
		else $error("Full fault level changed away from a subframe boundary.");
	property p_nv_stable; !$past(subframe_strobe_i) |-> $stable(fault_flag_excluding_validity_o); endproperty
	a_nv_stable: assert property (p_nv_stable)
		else $error("Reduced fault level changed away from a subframe boundary.");
	property p_nv_subset; fault_flag_excluding_validity_o |-> receive_fault_flag_o; endproperty
	a_nv_subset: assert property (p_nv_subset)
		else $error("Reduced fault level high without the full fault level.");
	property p_pulse; receive_fault_pulse_o |-> receive_fault_flag_o && $past(subframe_strobe_i); endproperty
	a_pulse: assert property (p_pulse)
		else $error("Fault pulse without a faulty subframe.");
	property p_valid; sample_valid_o |-> $past(subframe_strobe_i); endproperty
	a_valid: assert property (p_valid)
		else $error("Sample valid without a subframe.");
	property p_nonaudio; cs_bit1_i [*3] |-> non_audio_o; endproperty
	a_nonaudio: assert property (p_nonaudio)
		else $error("Non-audio low while channel status bit one is set.");
	property p_sync; $rose(burst_sync_i) |-> ##[1:3] non_audio_o; endproperty
	a_sync: assert property (p_sync)
		else $error("Burst sync did not raise non-audio.");
	property p_irq; irq_o |-> !irq_oe_n_o; endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt pin high while not driven.");
endmodule
bind ars_rx_status ars_rx_status_assertions i_ars_rx_status_assertions (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.subframe_strobe_i(subframe_strobe_i), .burst_sync_i(burst_sync_i), .cs_bit1_i(cs_bit1_i),
	.sample_valid_o(sample_valid_o), .non_audio_o(non_audio_o), .receive_fault_flag_o(receive_fault_flag_o),
	.fault_flag_excluding_validity_o(fault_flag_excluding_validity_o),
	.receive_fault_pulse_o(receive_fault_pulse_o), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));
`default_nettype wire

// ### sim/ars_rx_status_tb.sv
// Self-checking testbench of the receiver status block against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
module ars_rx_status_tb;
	import ars_pkg::*;
	localparam logic [6:0] ERRS [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h60, 7'h1b};
	logic        mclk_i = 1'b0, arst_n_i = 1'b0;
	logic        strb = 1'b0, pxz = 1'b0, py = 1'b0, cs1 = 1'b0, bsync = 1'b0, chb = 1'b0, pinmode = 1'b0;
	logic [6:0]  err = 7'h00, mask = 7'h00, sticky = 7'h00;
	logic [23:0] smp = 24'h00_0000, smp_o;
	logic [4:0]  fmt = 5'h00;
	logic [31:0] bpre = 32'h0000_0000, seed = 32'h0000_003c, rdat;
	logic [7:0]  addr, ctrl = 8'h00;
	logic        rd_s, wr_s, wreq, svalid, crystal_clock_input, bypass, naud, flag, nvf, pulse, irq, irq_oe_n;
	logic        wck, wck_oe_n, cfp, cfp_oe_n;
	logic [31:0] wdat;
	logic [23:0] prv [2] = '{24'h00_0000, 24'h00_0000};
	logic [23:0] hist [$];
	int          hold = 0, lat = 8, pth = 0, errors = 0, samples_checked = 0;
	// Free-running clock.
	always #5 mclk_i = !mclk_i;
	ars_host_model i_ars_host_model (.clk_i(mclk_i), .waitrequest_i(wreq), .readdata_i(rdat), .address_o(addr),
		.read_o(rd_s), .write_o(wr_s), .writedata_o(wdat));
	ars_rx_status #(.SYNC_TMO_CYC(20)) i_ars_rx_status (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .subframe_strobe_i(strb), .preamble_xz_i(pxz),
		.preamble_y_i(py), .word_check_error_i(err[0]), .line_code_error_i(err[1]),
		.jitter_margin_error_i(err[2]), .validity_error_i(err[3]), .unlock_error_i(err[4]),
		.status_block_checksum_error_i(err[5]), .subcode_checksum_error_i(err[6]), .burst_sync_i(bsync),
		.cs_bit1_i(cs1), .format_found_i(fmt), .burst_preamble_i(bpre), .sample_i(smp), .channel_b_i(chb),
		.sample_o(smp_o), .sample_valid_o(svalid), .slave_aligned_o(), .clk_switch_xti_o(crystal_clock_input),
		.deemph_bypass_o(bypass), .non_audio_o(naud), .receive_fault_flag_o(flag),
		.fault_flag_excluding_validity_o(nvf), .receive_fault_pulse_o(pulse), .combined_fault_pin_i(1'b0),
		.combined_fault_pin_o(cfp), .combined_fault_pin_oe_n_o(cfp_oe_n), .output_word_clock_i(1'b0),
		.output_word_clock_o(wck), .output_word_clock_oe_n_o(wck_oe_n), .irq_o(irq), .irq_oe_n_o(irq_oe_n));
	// Fixed-seed xorshift source for sample and status values.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected interrupt pin and enable for a style and an active state.
	function automatic logic [1:0] irqx(input int st, input logic a);
		if (st == 0) return {!a, 1'b0};
		if (st == 1) return {a, 1'b0};
		return {1'b0, !a};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] q;
		i_ars_host_model.xfer(1'b1, idx, d, q);
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		i_ars_host_model.xfer(1'b0, idx, 8'h00, q);
		chk({24'h00_0000, q}, {24'h00_0000, exp});
	endtask
	// Sends n subframes with one fault set and checks levels, pulse and the delayed treated sample.
	task automatic sub(input logic [6:0] e, input int n);
		logic [23:0] s;
		logic [23:0] t;
		logic        hit;
		for (int i = 0; i < n; i++) begin
			s = 24'(xs());
			hit = |(e & mask & (pinmode ? ARS_ALL_FAULTS : ARS_SAMPLE_FAULTS));
			t = !hit ? s : (hold == 0) ? prv[chb] : (hold == 1) ? 24'h00_0000 : s;
			@(posedge mclk_i);
			strb <= 1'b1;
			smp <= s;
			err <= e;
			pxz <= !chb;
			py <= chb;
			@(posedge mclk_i);
			strb <= 1'b0;
			pxz <= 1'b0;
			py <= 1'b0;
			hist.push_back(t);
			prv[chb] = t;
			chb <= !chb;
			sticky |= e & mask;
			@(negedge mclk_i);
			chk(32'(flag), 32'(|(e & mask)));
			chk(32'(nvf), 32'(|(e & mask & ~ARS_VALID_BIT)));
			chk(32'(pulse), 32'(|(e & mask)));
			chk(32'(crystal_clock_input), 32'(e[4] & (ctrl[0] | pinmode)));
			chk(32'({wck, wck_oe_n}), 32'({pth[4] & chb, !pth[4]}));
			chk(32'({cfp, cfp_oe_n}), 32'({|(e & mask & ~ARS_VALID_BIT), 1'b0}));
			chk(32'(svalid), 32'h0000_0001);
			if (hist.size() > lat) chk(32'(smp_o), 32'(hist[hist.size() - 1 - lat]));
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog sized well beyond the few hundred cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge mclk_i);
		errors++;
		tally_and_finish();
	end
	// Main sequence: registers, fault treatment per hold mode and latency, interrupts, non-audio, format.
	initial begin
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		rdc(ARS_IDX_FMASK, 8'h00);
		rdc(6'h3f, 8'h00);
		wr(ARS_IDX_FMASK, 8'h7f);
		mask = 7'h7f;
		ctrl = 8'h03;
		wr(ARS_IDX_CTRL, ctrl);
		sub(7'h00, 10);
		for (int d = 0; d < 2; d++) begin
			for (int h = 0; h < 3; h++) begin
				hold = h;
				lat = d ? 6 : 8;
				pth = h + 8 + 16 + d * 64;
				wr(ARS_IDX_PATH, 8'(pth));
				foreach (ERRS[k]) begin
					sub(ERRS[k], 1);
					sub(7'h00, 1);
				end
				rdc(ARS_IDX_FFLAGS, {1'b0, sticky});
				rdc(ARS_IDX_FFLAGS, 8'h00);
				sticky = 7'h00;
				$display("Test hold %0d direct %0d done", h, d);
			end
		end
		wr(ARS_IDX_FMASK, 8'h08);
		mask = 7'h08;
		sub(7'h09, 1);
		sub(7'h00, 1);
		rdc(ARS_IDX_FFLAGS, 8'h08);
		sticky = 7'h00;
		$display("Test fault mask done");
		wr(ARS_IDX_IMASK, 8'h01);
		wr(ARS_IDX_IMODE, 8'hfc);
		// Level mode after reset has already logged the fault and unlock sources.
		rdc(ARS_IDX_ISTAT, 8'h05);
		for (int st = 0; st < 3; st++) begin
			ctrl = 8'(1 + st * 2);
			wr(ARS_IDX_CTRL, ctrl);
			sub(7'h08, 1);
			repeat (2) @(negedge mclk_i);
			chk(32'({irq, irq_oe_n}), 32'(irqx(st, 1'b1)));
			sub(7'h00, 1);
			rdc(ARS_IDX_ISTAT, 8'h01);
			@(negedge mclk_i);
			chk(32'({irq, irq_oe_n}), 32'(irqx(st, 1'b0)));
		end
		wr(ARS_IDX_IMASK, 8'h00);
		sub(7'h08, 1);
		repeat (2) @(negedge mclk_i);
		chk(32'({irq, irq_oe_n}), 32'(irqx(2, 1'b0)));
		$display("Test interrupt done");
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk_i);
			cs1 <= xs() % 2 == 1;
			repeat (4) @(negedge mclk_i);
			chk(32'(naud), 32'(cs1));
			chk(32'(bypass), 32'(cs1));
		end
		@(posedge mclk_i);
		cs1 <= 1'b0;
		bsync <= 1'b1;
		@(posedge mclk_i);
		bsync <= 1'b0;
		repeat (3) @(negedge mclk_i);
		chk(32'(naud), 32'h0000_0001);
		repeat (40) @(negedge mclk_i);
		chk(32'(naud), 32'h0000_0000);
		$display("Test non-audio done");
		@(posedge mclk_i);
		fmt <= 5'(xs());
		bpre <= xs();
		repeat (3) @(posedge mclk_i);
		rdc(ARS_IDX_FORMAT, {3'b000, fmt});
		for (int k = 0; k < 4; k++) rdc(6'(ARS_IDX_BURST0 + k), bpre[8 * k +: 8]);
		$display("Test format done");
		// Pin configuration forces repeat on every fault but validity, checksum faults included.
		pth = 5;
		hold = 0;
		lat = 8;
		mask = 7'h77;
		pinmode = 1'b1;
		wr(ARS_IDX_PATH, 8'(pth));
		foreach (ERRS[k]) sub(ERRS[k], 1);
		$display("Test pin configuration done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
